// >>> lpc_core.sv
// Core slice: wait/stop handling, clock gating and the immediate-add and carry-branch opcodes.
// Assumes combinational program memory on one clock; other opcodes except clear-mask run as one-cycle no-ops.
`timescale 1ns/1ps
module lpc_core
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_resetn,
    // Program memory
    output logic [15:0] o_prog_addr,
    input wire logic [7:0] i_prog_data,
    // Interrupts and vector
    input wire lpc_pkg::lpc_irq_type i_irq,
    input wire logic [15:0] i_irq_vector_addr,
    output logic o_irq_taken,
    // Flags written by the rest of the core
    input wire logic i_flags_load,
    input wire lpc_pkg::lpc_flags_type i_flags,
    // Oscillator and configuration
    input wire logic i_osc_stable,
    input wire logic i_stop_enable,
    output logic o_osc_stop,
    // State
    output logic o_core_clk_en,
    output logic o_standby,
    output lpc_pkg::lpc_flags_type o_flags,
    output lpc_pkg::lpc_regs_type o_regs
);
    import lpc_pkg::*;
    typedef enum logic [2:0] {
        ST_VEC_HI, ST_VEC_LO, ST_FETCH, ST_OPERAND, ST_BRANCH, ST_WAIT, ST_STOP, ST_OSC_WAIT
    } lpc_state_type;
    lpc_state_type state;
    logic [7:0] opcode;
    logic [7:0] operand;
    logic [7:0] vec_hi;
    logic osc_meta;
    logic osc_sync;
    logic any_irq;
    logic take_irq;
    logic take_cond;

    assign o_prog_addr = o_regs.program_counter;
    assign any_irq = i_irq.irq | i_irq.ext_irq;
    assign take_irq = (state == ST_FETCH) && !o_flags.i && any_irq;
    assign take_cond = (opcode == OP_BRANCH_CARRY_SET) ? o_flags.c : !o_flags.c;

    // ========================================
    // Oscillator-stable synchroniser
    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            osc_meta <= 1'b0;
            osc_sync <= 1'b0;
        end
        else
        begin
            osc_meta <= i_osc_stable;
            osc_sync <= osc_meta;
        end
    end

    // ========================================
    // Sequencer
    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
            state <= ST_VEC_HI;
        else
        begin
            unique case (state)
                ST_VEC_HI: state <= ST_VEC_LO;
                ST_VEC_LO: state <= ST_FETCH;
                ST_FETCH:
                begin
                    if (take_irq)
                        state <= ST_VEC_HI;
                    else if (i_prog_data == OP_WAIT)
                        state <= ST_WAIT;
                    else if (i_prog_data == OP_STOP && i_stop_enable)
                        state <= ST_STOP;
                    else if (i_prog_data == OP_ADD_SIGNED_IMM_TO_STACK
                             || i_prog_data == OP_ADD_SIGNED_IMM_TO_INDEX
                             || i_prog_data == OP_BRANCH_CARRY_CLEAR
                             || i_prog_data == OP_BRANCH_CARRY_SET)
                        state <= ST_OPERAND;
                    else
                        state <= ST_FETCH;
                end
                ST_OPERAND:
                begin
                    if (opcode == OP_BRANCH_CARRY_CLEAR || opcode == OP_BRANCH_CARRY_SET)
                        state <= ST_BRANCH;
                    else
                        state <= ST_FETCH;
                end
                ST_BRANCH: state <= ST_FETCH;
                ST_WAIT:
                begin
                    if (any_irq)
                        state <= ST_VEC_HI;
                end
                ST_STOP:
                begin
                    // A stale stable flag from before stop would restart the clock early
                    if (i_irq.ext_irq && !osc_sync)
                        state <= ST_OSC_WAIT;
                end
                ST_OSC_WAIT:
                begin
                    if (osc_sync)
                        state <= ST_VEC_HI;
                end
            endcase
        end
    end

    // ========================================
    // Opcode and operand latches
    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            opcode <= 8'h00;
            operand <= 8'h00;
            vec_hi <= 8'h00;
        end
        else
        begin
            if (state == ST_FETCH)
                opcode <= i_prog_data;
            if (state == ST_OPERAND)
                operand <= i_prog_data;
            if (state == ST_VEC_HI)
                vec_hi <= i_prog_data;
        end
    end

    // ========================================
    // Program counter, stack pointer and index pair
    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_regs.program_counter <= RESET_VECTOR_ADDR;
            o_regs.stack_pointer <= RESET_STACK_POINTER;
            o_regs.index <= RESET_INDEX;
        end
        else
        begin
            unique case (state)
                ST_VEC_HI: o_regs.program_counter <= o_regs.program_counter + PC_STEP;
                ST_VEC_LO: o_regs.program_counter <= {vec_hi, i_prog_data};
                ST_FETCH:
                begin
                    if (take_irq)
                        o_regs.program_counter <= i_irq_vector_addr;
                    else
                        o_regs.program_counter <= o_regs.program_counter + PC_STEP;
                end
                ST_OPERAND:
                begin
                    o_regs.program_counter <= o_regs.program_counter + PC_STEP;
                    if (opcode == OP_ADD_SIGNED_IMM_TO_STACK)
                        o_regs.stack_pointer <= o_regs.stack_pointer
                                                + sext16(i_prog_data);
                    if (opcode == OP_ADD_SIGNED_IMM_TO_INDEX)
                        o_regs.index <= o_regs.index + sext16(i_prog_data);
                end
                ST_BRANCH:
                begin
                    if (take_cond)
                        o_regs.program_counter <= o_regs.program_counter
                                                  + sext16(operand);
                end
                ST_WAIT, ST_STOP:
                    o_regs.program_counter <= o_regs.program_counter;
                ST_OSC_WAIT:
                begin
                    if (osc_sync)
                        o_regs.program_counter <= i_irq_vector_addr;
                end
            endcase
            if (state == ST_WAIT && any_irq)
                o_regs.program_counter <= i_irq_vector_addr;
        end
    end

    // ========================================
    // Condition flags
    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
            o_flags <= RESET_FLAGS;
        else if (take_irq)
            o_flags.i <= 1'b1;
        else if (state == ST_FETCH && (i_prog_data == OP_WAIT
                 || i_prog_data == OP_CLEAR_MASK_INSTRUCTION))
            o_flags.i <= 1'b0;
        else if (state == ST_FETCH && i_prog_data == OP_STOP && i_stop_enable)
            o_flags.i <= 1'b0;
        else if (i_flags_load && state != ST_WAIT && state != ST_STOP
                 && state != ST_OSC_WAIT)
        begin
            o_flags <= i_flags;
            o_flags.one6 <= 1'b1;
            o_flags.one5 <= 1'b1;
        end
    end

    // ========================================
    // Clock gate, standby and wake pulse
    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_core_clk_en <= 1'b1;
            o_standby <= 1'b0;
            o_osc_stop <= 1'b0;
            o_irq_taken <= 1'b0;
        end
        else
        begin
            o_irq_taken <= take_irq || (state == ST_WAIT && any_irq)
                           || (state == ST_OSC_WAIT && osc_sync);
            if (state == ST_FETCH && !take_irq && (i_prog_data == OP_WAIT
                || (i_prog_data == OP_STOP && i_stop_enable)))
            begin
                o_core_clk_en <= 1'b0;
                o_standby <= 1'b1;
                o_osc_stop <= (i_prog_data == OP_STOP);
            end
            else if ((state == ST_WAIT && any_irq) || (state == ST_OSC_WAIT && osc_sync))
            begin
                o_core_clk_en <= 1'b1;
                o_standby <= 1'b0;
            end
            if (state == ST_STOP && i_irq.ext_irq && !osc_sync)
                o_osc_stop <= 1'b0;
        end
    end

    // ========================================
    // Checks
    default clocking cb_check @(posedge i_mclk);
    endclocking
    default disable iff (!i_resetn);

    sequence s_wait_fetched;
        state == ST_FETCH && !take_irq && i_prog_data == OP_WAIT;
    endsequence
    sequence s_stop_fetched;
        state == ST_FETCH && !take_irq && i_prog_data == OP_STOP && i_stop_enable;
    endsequence
    a_wait_clears_mask: assert property (
        s_wait_fetched |=> !o_flags.i && !o_core_clk_en && o_standby)
        else $error("wait did not clear mask and gate clock");
    a_stop_clears_mask: assert property (
        s_stop_fetched |=> !o_flags.i && o_osc_stop && state == ST_STOP)
        else $error("stop did not clear mask");
    a_wake_mask_clear: assert property (
        state == ST_WAIT && any_irq |=> !o_flags.i && o_irq_taken && o_core_clk_en)
        else $error("mask set after wake from wait");
    a_stop_wake_mask: assert property (
        state == ST_OSC_WAIT && osc_sync |=> !o_flags.i && o_irq_taken)
        else $error("mask set after wake from stop");
    a_clock_gated: assert property (
        (state == ST_WAIT || state == ST_STOP) |-> !o_core_clk_en)
        else $error("core clock running in low power");
    a_osc_hold_clock: assert property (
        state == ST_OSC_WAIT && !osc_sync |=> !o_core_clk_en)
        else $error("clock restarted before oscillator stable");
    a_stack_add: assert property (
        state == ST_FETCH && !take_irq && i_prog_data == OP_ADD_SIGNED_IMM_TO_STACK
        ##1 state == ST_OPERAND
        |=> o_regs.stack_pointer == $past(o_regs.stack_pointer) + $past(sext16(i_prog_data))
            && state == ST_FETCH && o_flags == $past(o_flags, 2))
        else $error("stack add wrong");
    a_index_add: assert property (
        state == ST_OPERAND && opcode == OP_ADD_SIGNED_IMM_TO_INDEX
        |=> o_regs.index == $past(o_regs.index) + $past(sext16(i_prog_data))
            && state == ST_FETCH)
        else $error("index add wrong");
    a_branch_target: assert property (
        state == ST_FETCH && !take_irq && i_prog_data == OP_BRANCH_CARRY_CLEAR
        ##1 !o_flags.c ##1 state == ST_BRANCH && !o_flags.c
        |=> o_regs.program_counter == $past(o_regs.program_counter, 3) + 16'h0002
            + sext16(operand) && state == ST_FETCH)
        else $error("branch carry clear target wrong");
    a_branch_set: assert property (
        state == ST_BRANCH && opcode == OP_BRANCH_CARRY_SET && o_flags.c
        |=> o_regs.program_counter == $past(o_regs.program_counter) + sext16(operand))
        else $error("branch carry set target wrong");
    a_branch_skip: assert property (
        state == ST_BRANCH && !take_cond
        |=> o_regs.program_counter == $past(o_regs.program_counter))
        else $error("untaken branch moved pc");
    a_mask_blocks: assert property (
        state == ST_FETCH && o_flags.i |=> !o_irq_taken)
        else $error("interrupt taken while masked");
endmodule // lpc_core

// >>> lpc_pkg.sv
// Constants, opcodes and carrier types for the low-power and opcode-subset core slice.
// Assumes one 125 MHz clock and an asynchronous-read program memory on the same clock.
// How it works
// - Wait or stop puts the whole part in standby until a wake event.
// - Wait clears the interrupt mask so maskable interrupts are accepted.
// - Leaving wait by an interrupt keeps the interrupt mask clear.
// - Stop clears the interrupt mask so external interrupts can wake it.
// - Leaving stop by an external interrupt keeps the interrupt mask clear.
// - Leaving wait or stop through reset sets the interrupt mask.
// - Wait and stop both gate off the core clock.
// - After stop the core clock restarts only once the oscillator is stable.
// - Opcode A7 adds the sign-extended immediate to the stack pointer, 2 cycles.
// - Opcode AF adds the sign-extended immediate to the index pair, 2 cycles.
// - Opcode 24 branches to pc plus 2 plus offset when carry clear, 3 cycles.
// - Opcode 25 branches to pc plus 2 plus offset when carry set, 3 cycles.
// - A set mask blocks maskable interrupts; reset sets it, clear-mask, wait, stop or a flags load can clear it.
package lpc_pkg;

    // ========================================
    // Opcodes
    localparam logic [7:0] OP_ADD_SIGNED_IMM_TO_STACK = 8'hA7;
    localparam logic [7:0] OP_ADD_SIGNED_IMM_TO_INDEX = 8'hAF;
    localparam logic [7:0] OP_BRANCH_CARRY_CLEAR = 8'h24;
    localparam logic [7:0] OP_BRANCH_CARRY_SET = 8'h25;
    localparam logic [7:0] OP_WAIT = 8'h8F;
    localparam logic [7:0] OP_STOP = 8'h8E;
    localparam logic [7:0] OP_CLEAR_MASK_INSTRUCTION = 8'h9A;

    // ========================================
    // Reset values and fixed addresses
    localparam logic [15:0] RESET_STACK_POINTER = 16'h00FF;
    localparam logic [15:0] RESET_VECTOR_ADDR = 16'hFFFE;
    localparam logic [15:0] RESET_INDEX = 16'h0000;
    localparam logic [15:0] PC_STEP = 16'h0001;

    // ========================================
    // Condition flags register, bit 7 down to bit 0
    typedef struct packed {
        logic v;
        logic one6;
        logic one5;
        logic h;
        logic i;
        logic n;
        logic z;
        logic c;
    } lpc_flags_type;

    localparam lpc_flags_type RESET_FLAGS = 8'h68;

    // Programmer-visible 16-bit registers
    typedef struct packed {
        logic [15:0] program_counter;
        logic [15:0] stack_pointer;
        logic [15:0] index;
    } lpc_regs_type;

    // Wake and exception requests
    typedef struct packed {
        logic irq;
        logic ext_irq;
    } lpc_irq_type;

    function automatic logic [15:0] sext16(input logic [7:0] b);
        sext16 = {{8{b[7]}}, b};
    endfunction

endpackage

// >>> lpc_prog_model.sv
// Far-side model: program memory read combinationally and the oscillator's stable flag.
// Assumes one clock; the stable flag falls while stop is held and settles OSC_DELAY cycles later.
`timescale 1ns/1ps
module lpc_prog_model
#(
    parameter int OSC_DELAY = 16
)
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_resetn,
    // Program memory
    input wire logic [15:0] i_prog_addr,
    output logic [7:0] o_prog_data,
    // Oscillator
    input wire logic i_osc_stop,
    output logic o_osc_stable
);
    logic [7:0] mem [0:65535];
    int settle;

    // ========================================
    // Memory
    // Unwritten bytes hold an opcode that the core runs as a no-op
    task automatic clear();
        for (int a = 0; a < 65536; a++)
        begin
            mem[a] = 8'h9D;
        end
    endtask

    task automatic put(input logic [15:0] a, input logic [7:0] d);
        mem[a] = d;
    endtask

    assign o_prog_data = mem[i_prog_addr];

    // ========================================
    // Oscillator
    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            settle <= 0;
        end
        else if (i_osc_stop)
        begin
            settle <= OSC_DELAY;
        end
        else if (settle > 0)
        begin
            settle <= settle - 1;
        end
    end

    assign o_osc_stable = !i_osc_stop && settle == 0;
endmodule // lpc_prog_model

// >>> tb_cpu_lowpower_and_opcode_subset.sv
// Self-checking bench for the core slice: immediate adds, carry branches, wait and stop.
// Assumes the reset vector points at 0100 and the interrupt vector bytes sit at 0200.
`timescale 1ns/1ps
module tb_cpu_lowpower_and_opcode_subset;
    import lpc_pkg::*;
    localparam int OSC_DELAY = 12;
    logic i_mclk, i_resetn, o_irq_taken, i_flags_load, i_osc_stable, i_stop_enable;
    logic o_osc_stop, o_core_clk_en, o_standby;
    logic [15:0] o_prog_addr, i_irq_vector_addr;
    logic [7:0] i_prog_data;
    lpc_irq_type i_irq;
    lpc_flags_type i_flags, o_flags;
    lpc_regs_type o_regs;
    int errors, tests_run, cnt;

    lpc_core DUT (.i_mclk(i_mclk), .i_resetn(i_resetn), .o_prog_addr(o_prog_addr),
        .i_prog_data(i_prog_data), .i_irq(i_irq), .i_irq_vector_addr(i_irq_vector_addr),
        .o_irq_taken(o_irq_taken), .i_flags_load(i_flags_load), .i_flags(i_flags),
        .i_osc_stable(i_osc_stable), .i_stop_enable(i_stop_enable), .o_osc_stop(o_osc_stop),
        .o_core_clk_en(o_core_clk_en), .o_standby(o_standby), .o_flags(o_flags),
        .o_regs(o_regs));
    lpc_prog_model #(.OSC_DELAY(OSC_DELAY)) model (.i_mclk(i_mclk), .i_resetn(i_resetn),
        .i_prog_addr(o_prog_addr), .o_prog_data(i_prog_data), .i_osc_stop(o_osc_stop),
        .o_osc_stable(i_osc_stable));

    // ========================================
    // Clock, watchdog and common tasks
    initial
    begin
        i_mclk = 1'b0;
        forever #4 i_mclk = ~i_mclk;
    end

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        #160000;
        errors++;
        stop_test();
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge i_mclk);
    endtask

    task automatic wait_addr(input logic [15:0] a);
        for (cnt = 0; cnt < 400 && o_prog_addr !== a; cnt++)
            @(negedge i_mclk);
        check("fetch_address", o_prog_addr, a);
    endtask

    task automatic pulse_reset();
        @(posedge i_mclk);
        i_resetn <= 1'b0;
        repeat (4) @(posedge i_mclk);
        i_resetn <= 1'b1;
    endtask

    // Loads four program bytes at 0100, resets and waits for the first fetch
    task automatic boot(input logic [7:0] b0, b1, b2, b3);
        model.clear();
        model.put(16'hFFFE, 8'h01);
        model.put(16'hFFFF, 8'h00);
        model.put(16'h0200, 8'h03);
        model.put(16'h0201, 8'h00);
        model.put(16'h0100, b0);
        model.put(16'h0101, b1);
        model.put(16'h0102, b2);
        model.put(16'h0103, b3);
        pulse_reset();
        wait_addr(16'h0100);
    endtask

    // ========================================
    // Scenarios
    task automatic test_adds();
        boot(8'hA7, 8'h80, 8'hAF, 8'h7F);
        step(2);
        check("sp_after_add", o_regs.stack_pointer, 16'h007F);
        check("pc_after_stack_add", o_prog_addr, 16'h0102);
        step(2);
        check("index_after_add", o_regs.index, 16'h007F);
        check("pc_after_index_add", o_prog_addr, 16'h0104);
        check("flags_after_adds", 16'(o_flags), 16'h0068);
    endtask

    task automatic test_branches();
        boot(8'h24, 8'h10, 8'h24, 8'h00);
        model.put(16'h0112, 8'h25);
        model.put(16'h0113, 8'hF0);
        model.put(16'h0114, 8'h25);
        model.put(16'h0115, 8'hEC);
        step(3);
        check("carry_clear_taken", o_prog_addr, 16'h0112);
        step(3);
        check("carry_set_not_taken", o_prog_addr, 16'h0114);
        @(posedge i_mclk);
        i_flags_load <= 1'b1;
        @(posedge i_mclk);
        i_flags_load <= 1'b0;
        step(2);
        check("carry_set_taken", o_prog_addr, 16'h0102);
        check("flags_after_branch", 16'(o_flags), 16'h0069);
        step(3);
        check("carry_clear_not_taken", o_prog_addr, 16'h0104);
    endtask

    task automatic test_wait();
        boot(8'h8F, 8'h9D, 8'h9D, 8'h9D);
        step(4);
        check("wait_mask", 16'(o_flags.i), 16'h0000);
        check("wait_clock_off", 16'(o_core_clk_en), 16'h0000);
        check("wait_standby", 16'(o_standby), 16'h0001);
        @(posedge i_mclk);
        i_irq.irq <= 1'b1;
        @(posedge i_mclk);
        i_irq.irq <= 1'b0;
        step(1);
        check("wait_wake_clock", 16'(o_core_clk_en), 16'h0001);
        check("wait_wake_standby", 16'(o_standby), 16'h0000);
        check("wait_wake_taken", 16'(o_irq_taken), 16'h0001);
        check("wait_vector_addr", o_prog_addr, 16'h0200);
        wait_addr(16'h0300);
        check("wait_exit_mask", 16'(o_flags.i), 16'h0000);
    endtask

    task automatic test_stop();
        boot(8'h8E, 8'h9D, 8'h9D, 8'h9D);
        step(1);
        check("stop_mask", 16'(o_flags.i), 16'h0000);
        check("stop_clock_off", 16'(o_core_clk_en), 16'h0000);
        check("stop_osc_off", 16'(o_osc_stop), 16'h0001);
        @(posedge i_mclk);
        i_irq.irq <= 1'b1;
        step(4);
        check("stop_ignores_irq", 16'(o_standby), 16'h0001);
        @(posedge i_mclk);
        i_irq.irq <= 1'b0;
        i_irq.ext_irq <= 1'b1;
        @(posedge i_mclk);
        i_irq.ext_irq <= 1'b0;
        for (cnt = 0; cnt < 300 && o_core_clk_en !== 1'b1; cnt++)
            @(negedge i_mclk);
        check("osc_wait_long", 16'(cnt >= OSC_DELAY), 16'h0001);
        check("osc_restarted", 16'(o_osc_stop), 16'h0000);
        wait_addr(16'h0300);
        check("stop_exit_mask", 16'(o_flags.i), 16'h0000);
    endtask

    task automatic test_reset_in_wait();
        @(posedge i_mclk);
        i_stop_enable <= 1'b0;
        boot(8'h8E, 8'h8F, 8'h9D, 8'h9D);
        step(1);
        check("stop_disabled_noop", o_prog_addr, 16'h0101);
        check("stop_disabled_osc", 16'(o_osc_stop), 16'h0000);
        step(2);
        check("wait_entered", 16'(o_standby), 16'h0001);
        pulse_reset();
        check("reset_exit_flags", 16'(o_flags), 16'h0068);
        check("reset_exit_clock", 16'(o_core_clk_en), 16'h0001);
        wait_addr(16'h0100);
        check("reset_mask_held", 16'(o_flags.i), 16'h0001);
        @(posedge i_mclk);
        i_stop_enable <= 1'b1;
    endtask

    // Masked request is held off, clear-mask lets it in, taking it sets the mask
    task automatic test_clear_mask();
        boot(8'h9D, 8'h9A, 8'h9D, 8'h9D);
        @(posedge i_mclk);
        i_irq.irq <= 1'b1;
        step(2);
        check("masked_irq_pc", o_prog_addr, 16'h0102);
        check("masked_irq_taken", 16'(o_irq_taken), 16'h0000);
        check("clear_mask", 16'(o_flags.i), 16'h0000);
        step(1);
        check("irq_taken_pulse", 16'(o_irq_taken), 16'h0001);
        check("irq_sets_mask", 16'(o_flags.i), 16'h0001);
        check("irq_vector_addr", o_prog_addr, 16'h0200);
        @(posedge i_mclk);
        i_irq.irq <= 1'b0;
        wait_addr(16'h0300);
        check("irq_taken_one_cycle", 16'(o_irq_taken), 16'h0000);
    endtask

    // ========================================
    // Main sequence
    initial
    begin
        errors = 0;
        tests_run = 0;
        i_resetn = 1'b0;
        i_irq = '0;
        i_irq_vector_addr = 16'h0200;
        i_flags_load = 1'b0;
        i_flags = 8'h69;
        i_stop_enable = 1'b1;
        test_adds();
        test_branches();
        test_wait();
        test_stop();
        test_clear_mask();
        test_reset_in_wait();
        stop_test();
    end
endmodule // tb_cpu_lowpower_and_opcode_subset
